// *** hdl/output_channel_divider_config.sv ***
/*
  one clock output channel: axi4-lite registers, input select, sync,
  divider and output driver control.
  assumes rf1_clk, rf2_clk and sync_in are asynchronous pins slow enough
  (below a quarter of mclk) to be sampled edge by edge.
*/
// Implementation choice: the AXI4-Lite register port.
module output_channel_divider_config
  import clkdist_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic srst,
  // axi4-lite write address and data
  input wire logic [clkdist_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [clkdist_pkg::DATA_W-1:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // axi4-lite write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read
  input wire logic [clkdist_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [clkdist_pkg::DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // clock inputs and sync pin
  input wire logic rf1_clk,
  input wire logic rf2_clk,
  input wire logic sync_in,
  // output driver
  output clkdist_pkg::out_pins_t first_clock_output
);
  import clkdist_pkg::*;

  localparam int PIN_SYNC = 2;
  localparam int PIN_RF2 = 1;
  localparam int PIN_RF1 = 0;

  // bus holding registers
  logic [IDX_W-1:0] aw_idx_r;
  logic [REG_W-1:0] w_data_r;
  logic w_lane_r;
  logic aw_held_r;
  logic w_held_r;
  logic wr_en;
  logic wr_ok;
  logic [IDX_W-1:0] ar_idx;
  logic [DATA_W-1:0] rd_word;
  logic rd_ok;

  // programmed state
  drv_cfg_t drv_cfg_r;
  logic [REG_W-1:0] ratio_lo_r;
  logic [1:0] ratio_hi_r;
  logic powered_off_r;
  logic rf_sel_r;
  logic [PHASE_W-1:0] phase_r;
  logic sync_mask_r;
  logic synced_r;

  // pin sampling
  logic [2:0] meta_r;
  logic [2:0] stab_r;
  logic [2:0] last_r;

  logic tick;
  logic sw_sync;
  logic sync_evt;
  logic sync_load;
  logic hold;
  logic div_clk;
  logic [RATIO_W-1:0] ratio;

  function automatic logic is_mapped(input logic [IDX_W-1:0] idx);
    is_mapped = idx == IDX_SYNC_CTRL || idx == IDX_DRV_CFG
      || idx == IDX_RATIO_LO || idx == IDX_CTRL_HI || idx == IDX_PHASE
      || idx == IDX_STATUS_CMD;
  endfunction : is_mapped

  // write address channel: one write in flight, released after response
  always_ff @(posedge mclk) begin
    if (srst) begin
      aw_held_r <= 1'b0;
      aw_idx_r <= '0;
      awready <= 1'b1;
    end else if (awvalid && awready) begin
      aw_held_r <= 1'b1;
      aw_idx_r <= awaddr[IDX_W+1:2];
      awready <= 1'b0;
    end else if (bvalid && bready) begin
      aw_held_r <= 1'b0;
      awready <= 1'b1;
    end
  end

  // write data channel, independent of the address channel
  always_ff @(posedge mclk) begin
    if (srst) begin
      w_held_r <= 1'b0;
      w_data_r <= '0;
      w_lane_r <= 1'b0;
      wready <= 1'b1;
    end else if (wvalid && wready) begin
      w_held_r <= 1'b1;
      w_data_r <= wdata[REG_W-1:0];
      w_lane_r <= wstrb[0];
      wready <= 1'b0;
    end else if (bvalid && bready) begin
      w_held_r <= 1'b0;
      wready <= 1'b1;
    end
  end

  // registers are eight bits wide, so only byte lane 0 writes them
  assign wr_en = aw_held_r && w_held_r && !bvalid;
  assign wr_ok = wr_en && w_lane_r;

  always_ff @(posedge mclk) begin
    if (srst) begin
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else if (wr_en) begin
      bvalid <= 1'b1;
      bresp <= is_mapped(aw_idx_r) ? RESP_OKAY : RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // driver configuration
  always_ff @(posedge mclk) begin
    if (srst) begin
      drv_cfg_r <= RST_DRV_CFG;
    end else if (wr_ok && aw_idx_r == IDX_DRV_CFG) begin
      drv_cfg_r <= w_data_r;
    end
  end

  // divide ratio and channel control
  always_ff @(posedge mclk) begin
    if (srst) begin
      ratio_lo_r <= RST_RATIO_LO;
      ratio_hi_r <= RST_RATIO_HI;
      powered_off_r <= 1'b0;
      rf_sel_r <= 1'b0;
    end else if (wr_ok && aw_idx_r == IDX_RATIO_LO) begin
      ratio_lo_r <= w_data_r;
    end else if (wr_ok && aw_idx_r == IDX_CTRL_HI) begin
      ratio_hi_r <= w_data_r[1:0];
      powered_off_r <= w_data_r[BIT_PWR_OFF];
      rf_sel_r <= w_data_r[BIT_RF_SEL];
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      phase_r <= RST_PHASE;
      sync_mask_r <= 1'b0;
    end else if (wr_ok && aw_idx_r == IDX_PHASE) begin
      phase_r <= w_data_r[PHASE_W-1:0];
    end else if (wr_ok && aw_idx_r == IDX_SYNC_CTRL) begin
      sync_mask_r <= w_data_r[BIT_SYNC_MASK];
    end
  end

  assign ratio = {ratio_hi_r, ratio_lo_r};

  // read channel: data registered on the same edge that takes the address
  assign ar_idx = araddr[IDX_W+1:2];

  always_comb begin
    rd_word = '0;
    rd_ok = 1'b1;
    if (ar_idx == IDX_SYNC_CTRL) begin
      rd_word[BIT_SYNC_MASK] = sync_mask_r;
    end else if (ar_idx == IDX_DRV_CFG) begin
      rd_word[REG_W-1:0] = drv_cfg_r;
    end else if (ar_idx == IDX_RATIO_LO) begin
      rd_word[REG_W-1:0] = ratio_lo_r;
    end else if (ar_idx == IDX_CTRL_HI) begin
      rd_word[1:0] = ratio_hi_r;
      rd_word[BIT_PWR_OFF] = powered_off_r;
      rd_word[BIT_RF_SEL] = rf_sel_r;
    end else if (ar_idx == IDX_PHASE) begin
      rd_word[PHASE_W-1:0] = phase_r;
    end else if (ar_idx == IDX_STATUS_CMD) begin
      rd_word[BIT_STAT_SYNCED] = synced_r;
      rd_word[BIT_STAT_CLK] = div_clk;
      rd_word[BIT_STAT_PWR] = powered_off_r;
    end else begin
      rd_ok = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= rd_word;
      rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid && rready) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
    end
  end

  // pin synchronisers; the edge detectors read the second and third stages, never the first
  always_ff @(posedge mclk) begin
    if (srst) begin
      meta_r <= '0;
      stab_r <= '0;
      last_r <= '0;
    end else begin
      meta_r <= {sync_in, rf2_clk, rf1_clk};
      stab_r <= meta_r;
      last_r <= stab_r;
    end
  end

  // each edge of the input clock is one half period of divider time;
  // changing the select mid-run may cost or add one half period
  assign tick = rf_sel_r
    ? stab_r[PIN_RF2] ^ last_r[PIN_RF2]
    : stab_r[PIN_RF1] ^ last_r[PIN_RF1];

  assign sw_sync = wr_ok && aw_idx_r == IDX_STATUS_CMD
    && w_data_r[BIT_SW_SYNC];
  assign sync_evt = sw_sync || (stab_r[PIN_SYNC] && !last_r[PIN_SYNC]);
  assign sync_load = sync_evt && !sync_mask_r && !powered_off_r;
  assign hold = !sync_mask_r && !synced_r;

  // an unmasked channel stays static until a sync; a masked channel runs without one
  always_ff @(posedge mclk) begin
    if (srst || powered_off_r) begin
      synced_r <= 1'b0;
    end else if (sync_load) begin
      synced_r <= 1'b1;
    end
  end

  chan_divider #(
    .RATIO_W(RATIO_W),
    .PHASE_W(PHASE_W)
  ) u_divider (
    .mclk(mclk),
    .srst(srst),
    .tick(tick),
    .ratio(ratio),
    .phase(phase_r),
    .powered_off(powered_off_r),
    .hold(hold),
    .sync_load(sync_load),
    .div_clk(div_clk)
  );

  clk_out_stage u_out_stage (
    .mclk(mclk),
    .srst(srst),
    .div_clk(div_clk),
    .cfg(drv_cfg_r),
    .pins(first_clock_output)
  );

  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  sequence s_ratio_lo_write;
    wr_ok && aw_idx_r == IDX_RATIO_LO;
  endsequence

  sequence s_masked_sync;
    sync_mask_r && sync_evt;
  endsequence

  property p_ratio_lo;
    s_ratio_lo_write |=> ratio[7:0] == $past(w_data_r)
      && ratio[9:8] == $past(ratio_hi_r);
  endproperty
  a_ratio_lo: assert property (p_ratio_lo)
    else $error("low divide bits not taken from the written byte");

  property p_power_off;
    powered_off_r |=> !div_clk ##1 !first_clock_output.p
      || first_clock_output.cmos_mode;
  endproperty
  a_power_off: assert property (p_power_off)
    else $error("divider still runs while powered off");

  property p_rf_select;
    !rf_sel_r && (stab_r[PIN_RF2] ^ last_r[PIN_RF2])
      && !(stab_r[PIN_RF1] ^ last_r[PIN_RF1]) |-> !tick;
  endproperty
  a_rf_select: assert property (p_rf_select)
    else $error("unselected rf divider advanced the channel");

  property p_format_off;
    !drv_cfg_r.cmos33 && (drv_cfg_r.format == FMT_OFF
      || drv_cfg_r.format == 3'h3 || drv_cfg_r.format == 3'h7)
      |=> !first_clock_output.p_oe && !first_clock_output.n_oe;
  endproperty
  a_format_off: assert property (p_format_off)
    else $error("off or reserved format left a leg driving");

  property p_polarity;
    drv_cfg_r.format == FMT_CMOS_PN |=> first_clock_output.p
      == ($past(div_clk) ^ $past(drv_cfg_r.polarity[1]))
      && first_clock_output.n
      == ($past(div_clk) ^ ($past(drv_cfg_r.polarity[1])
      ~^ $past(drv_cfg_r.polarity[0])));
  endproperty
  a_polarity: assert property (p_polarity)
    else $error("cmos leg polarity wrong");

  property p_enable;
    !drv_cfg_r.cmos33 && !drv_cfg_r.enable
      |=> !first_clock_output.p_oe && !first_clock_output.n_oe;
  endproperty
  a_enable: assert property (p_enable)
    else $error("driver on with enable clear");

  property p_cmos33;
    drv_cfg_r.cmos33 && drv_cfg_r.format == FMT_CMOS_PN
      |=> first_clock_output.cmos_mode && first_clock_output.p_oe
      && first_clock_output.n_oe;
  endproperty
  a_cmos33: assert property (p_cmos33)
    else $error("3.3 v cmos mode did not drive both legs");

  property p_strength;
    !drv_cfg_r.cmos33 && drv_cfg_r.format != FMT_LVDS
      |=> !first_clock_output.boost;
  endproperty
  a_strength: assert property (p_strength)
    else $error("boost outside lvds and 3.3 v cmos");

  property p_mask;
    s_masked_sync |=> $stable(synced_r) ##0 !$past(sync_load);
  endproperty
  a_mask: assert property (p_mask)
    else $error("masked channel reacted to sync");

endmodule : output_channel_divider_config

// *** hdl/clkdist_pkg.sv ***
/*
  shared constants and carriers for the clock output channel block.
  assumes a 32-bit axi4-lite register bus and one 50 MHz system clock.
*/
package clkdist_pkg;

  localparam int DATA_W = 32;
  localparam int ADDR_W = 16;
  localparam int IDX_W = 12;
  localparam int RATIO_W = 10;
  localparam int PHASE_W = 6;
  localparam int REG_W = 8;

  // register indices; the byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_SYNC_CTRL = 12'h500;
  localparam logic [IDX_W-1:0] IDX_DRV_CFG = 12'h501;
  localparam logic [IDX_W-1:0] IDX_RATIO_LO = 12'h502;
  localparam logic [IDX_W-1:0] IDX_CTRL_HI = 12'h503;
  localparam logic [IDX_W-1:0] IDX_PHASE = 12'h504;
  localparam logic [IDX_W-1:0] IDX_STATUS_CMD = 12'h510;

  // field positions
  localparam int BIT_SYNC_MASK = 4;
  localparam int BIT_PWR_OFF = 3;
  localparam int BIT_RF_SEL = 2;
  localparam int BIT_SW_SYNC = 0;
  localparam int BIT_STAT_SYNCED = 1;
  localparam int BIT_STAT_CLK = 2;
  localparam int BIT_STAT_PWR = 3;

  // reset values
  localparam logic [REG_W-1:0] RST_DRV_CFG = 8'h10;
  localparam logic [REG_W-1:0] RST_RATIO_LO = 8'h00;
  localparam logic [1:0] RST_RATIO_HI = 2'h0;
  localparam logic [PHASE_W-1:0] RST_PHASE = 6'h00;

  // output format codes
  localparam logic [2:0] FMT_OFF = 3'h0;
  localparam logic [2:0] FMT_HSTL = 3'h1;
  localparam logic [2:0] FMT_LVDS = 3'h2;
  localparam logic [2:0] FMT_CMOS_PN = 3'h4;
  localparam logic [2:0] FMT_CMOS_P = 3'h5;
  localparam logic [2:0] FMT_CMOS_N = 3'h6;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // layout matches the driver configuration register bit for bit
  typedef struct packed {
    logic cmos33;
    logic [2:0] format;
    logic [1:0] polarity;
    logic strength;
    logic enable;
  } drv_cfg_t;

  typedef struct packed {
    logic p;
    logic n;
    logic p_oe;
    logic n_oe;
    logic boost;
    logic cmos_mode;
  } out_pins_t;

endpackage : clkdist_pkg

// *** hdl/chan_divider.sv ***
/*
  channel divider counting half periods of its selected input clock.
  assumes tick marks each edge of the input clock, one mclk pulse per edge.
*/
module chan_divider #(
  parameter int RATIO_W = 10,
  parameter int PHASE_W = 6
) (
  // clock and reset
  input wire logic mclk,
  input wire logic srst,
  // control
  input wire logic tick,
  input wire logic [RATIO_W-1:0] ratio,
  input wire logic [PHASE_W-1:0] phase,
  input wire logic powered_off,
  input wire logic hold,
  input wire logic sync_load,
  // divided clock
  output logic div_clk
);
  logic [RATIO_W-1:0] cnt_r;
  logic [PHASE_W-1:0] delay_r;

  // toggling every ratio+1 half periods gives a period of ratio+1 inputs
  always_ff @(posedge mclk) begin
    if (srst || powered_off) begin
      cnt_r <= '0;
      delay_r <= '0;
      div_clk <= 1'b0;
    end else if (sync_load) begin
      cnt_r <= '0;
      delay_r <= phase;
      div_clk <= 1'b0;
    end else if (tick && !hold) begin
      if (delay_r != '0) begin
        delay_r <= delay_r - 1'b1;
      end else if (cnt_r == ratio) begin
        cnt_r <= '0;
        div_clk <= ~div_clk;
      end else begin
        cnt_r <= cnt_r + 1'b1;
      end
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  property p_div_toggle;
    tick && !hold && !sync_load && !powered_off && delay_r == '0
      && cnt_r == ratio |=> div_clk != $past(div_clk);
  endproperty
  a_div_toggle: assert property (p_div_toggle)
    else $error("divider did not toggle at terminal count");

  property p_phase_load;
    sync_load && !powered_off |=> delay_r == $past(phase) && !div_clk;
  endproperty
  a_phase_load: assert property (p_phase_load)
    else $error("start phase not loaded on sync");

endmodule : chan_divider

// *** hdl/clk_out_stage.sv ***
/*
  output driver mapping: format, polarity, enable and strength to pin legs.
  assumes the divided clock and configuration come from the same mclk.
*/
module clk_out_stage
  import clkdist_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic srst,
  // source
  input wire logic div_clk,
  input wire clkdist_pkg::drv_cfg_t cfg,
  // driver
  output clkdist_pkg::out_pins_t pins
);
  logic drv_on;
  logic p_act;
  logic n_act;
  logic cmos_fmt;
  out_pins_t pins_nxt;

  always_comb begin
    cmos_fmt = cfg.format == FMT_CMOS_PN || cfg.format == FMT_CMOS_P
      || cfg.format == FMT_CMOS_N;
    // reserved codes and the off code activate no leg
    p_act = cfg.format == FMT_HSTL || cfg.format == FMT_LVDS
      || cfg.format == FMT_CMOS_PN || cfg.format == FMT_CMOS_P;
    n_act = cfg.format == FMT_HSTL || cfg.format == FMT_LVDS
      || cfg.format == FMT_CMOS_PN || cfg.format == FMT_CMOS_N;
    drv_on = cfg.cmos33 ? 1'b1 : cfg.enable;
    pins_nxt.cmos_mode = cfg.cmos33 || cmos_fmt;
    pins_nxt.p_oe = drv_on && p_act;
    pins_nxt.n_oe = drv_on && n_act;
    if (pins_nxt.cmos_mode) begin
      pins_nxt.p = div_clk ^ cfg.polarity[1];
      // the n leg is inverted when both polarity bits agree
      pins_nxt.n = div_clk ^ (cfg.polarity[1] ~^ cfg.polarity[0]);
    end else begin
      pins_nxt.p = div_clk;
      pins_nxt.n = ~div_clk;
    end
    // 1.8 v cmos and hstl stay at low strength
    pins_nxt.boost = cfg.strength
      && (cfg.cmos33 || cfg.format == FMT_LVDS);
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      pins <= '0;
    end else begin
      pins <= pins_nxt;
    end
  end

endmodule : clk_out_stage

// *** testbench/clk_receiver.sv ***
/*
  downstream clock receiver model: counts rises of the p leg and spacing.
  assumes the pins are registered on mclk, so spans are whole mclk cycles.
*/
module clk_receiver
  import clkdist_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic srst,
  // observed output
  input wire clkdist_pkg::out_pins_t pins,
  // measurements
  output logic [15:0] rise_count,
  output logic [15:0] last_period
);
  timeunit 1ns;
  timeprecision 100ps;
  logic p_r;
  logic [15:0] span_r;
  // an undriven leg carries no clock, so its level is never counted
  always_ff @(posedge mclk) begin
    p_r <= pins.p & pins.p_oe;
    if (srst) begin
      span_r <= 16'h0;
      rise_count <= 16'h0;
      last_period <= 16'h0;
    end else if (pins.p && pins.p_oe && !p_r) begin
      span_r <= 16'h1;
      rise_count <= rise_count + 16'h1;
      last_period <= span_r;
    end else begin
      span_r <= span_r + 16'h1;
    end
  end
endmodule : clk_receiver

// *** testbench/output_channel_divider_config_tb.sv ***
/*
  self-checking bench: axi4-lite master tasks, register and pin tests.
  assumes rf inputs well below mclk/4 and the clk_receiver model.
*/
module output_channel_divider_config_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import clkdist_pkg::*;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
  logic [DATA_W-1:0] wdata = '0, rdata;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, sync_in = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic rf1_clk = 1'b0, rf2_clk = 1'b0;
  logic [1:0] rf1_div_r = 2'h0;
  logic [2:0] rf2_div_r = 3'h0;
  out_pins_t first_clock_output;
  logic [15:0] rise_count, last_period;
  int err_total = 0;
  int samples_checked = 0;
  // pins {p,n,p_oe,n_oe,boost,cmos_mode} with the divided clock held low
  // cmos33 rows keep a cmos format
  logic [7:0] cfg_tab [14] = '{8'h11, 8'h10, 8'h23, 8'h43, 8'h47, 8'h49,
    8'h4d, 8'h51, 8'h61, 8'h31, 8'h71, 8'h00, 8'hc2, 8'hd0};
  logic [5:0] pin_tab [14] = '{6'h1c, 6'h00, 6'h1e, 6'h1d, 6'h0d, 6'h2d,
    6'h3d, 6'h09, 6'h15, 6'h00, 6'h00, 6'h00, 6'h1f, 6'h09};
  logic [5:0] msk_tab [14] = '{6'h3f, 6'h0f, 6'h3f, 6'h3f, 6'h3f, 6'h3f,
    6'h3f, 6'h2f, 6'h1f, 6'h0e, 6'h0e, 6'h0e, 6'h3f, 6'h2f};
  // {ratio low, control high, expected period in mclk}
  logic [31:0] per_tab [5] = '{32'h00000006, 32'h02000012, 32'h00010606,
    32'hff031800, 32'h01040014};

  always #10 mclk = ~mclk;
  // rf1 period 6 mclk, rf2 period 10 mclk
  always @(posedge mclk) begin
    rf1_div_r <= (rf1_div_r == 2'h2) ? 2'h0 : rf1_div_r + 2'h1;
    rf2_div_r <= (rf2_div_r == 3'h4) ? 3'h0 : rf2_div_r + 3'h1;
    if (rf1_div_r == 2'h2) rf1_clk <= ~rf1_clk;
    if (rf2_div_r == 3'h4) rf2_clk <= ~rf2_clk;
  end

  output_channel_divider_config u_dut (.mclk(mclk), .srst(srst),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .rf1_clk(rf1_clk), .rf2_clk(rf2_clk),
    .sync_in(sync_in), .first_clock_output(first_clock_output));
  clk_receiver u_rx (.mclk(mclk), .srst(srst), .pins(first_clock_output),
    .rise_count(rise_count), .last_period(last_period));

  task automatic end_of_test();
    if (err_total == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_of_test

  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got %h expected %h", $time, got, exp);
    end
  endtask : check_val

  task automatic check_pins(input logic [5:0] exp, input logic [5:0] msk);
    samples_checked++;
    if ((first_clock_output & msk) !== (exp & msk)) begin
      err_total++;
      $display("BAD t=%0t pins %h expected %h", $time, first_clock_output,
        exp);
    end
  endtask : check_pins

  task automatic wr(input logic [IDX_W-1:0] idx, input logic [7:0] d,
    input logic [3:0] s, output logic [1:0] r);
    logic busy;
    @(posedge mclk);
    awaddr <= {2'h0, idx, 2'h0};
    wdata <= {24'h0, d};
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    busy = 1'b1;
    while (busy) begin
      @(posedge mclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        r = bresp;
        bready <= 1'b0;
        busy = 1'b0;
      end
    end
  endtask : wr

  task automatic rd(input logic [IDX_W-1:0] idx, output logic [31:0] d,
    output logic [1:0] r);
    logic busy;
    @(posedge mclk);
    araddr <= {2'h0, idx, 2'h0};
    arvalid <= 1'b1;
    rready <= 1'b1;
    busy = 1'b1;
    while (busy) begin
      @(posedge mclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        busy = 1'b0;
      end
    end
  endtask : rd

  task automatic rd_check(input logic [IDX_W-1:0] idx,
    input logic [31:0] msk, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    rd(idx, d, r);
    check_val(d & msk, exp);
  endtask : rd_check

  task automatic wait_rises(input int n);
    logic [15:0] n0;
    n0 = rise_count;
    while (rise_count - n0 < n) @(posedge mclk);
  endtask : wait_rises

  // sync at a fixed rf1 phase so the start delay is repeatable
  task automatic sync_delay(output int t);
    logic [1:0] r;
    logic [15:0] n0;
    while (!(rf1_div_r == 2'h0 && rf1_clk == 1'b0)) @(posedge mclk);
    wr(IDX_STATUS_CMD, 8'h01, 4'h1, r);
    n0 = rise_count;
    t = 0;
    while (rise_count == n0) begin
      @(posedge mclk);
      t++;
    end
  endtask : sync_delay

  initial begin : watchdog
    #2000000;
    err_total++;
    $display("BAD t=%0t watchdog expired", $time);
    end_of_test();
  end

  initial begin : main
    logic [31:0] d;
    logic [1:0] r;
    logic [15:0] n0;
    int t0, t1;
    repeat (16) @(posedge mclk);
    srst <= 1'b0;
    rd_check(IDX_SYNC_CTRL, 32'h10, 32'h0);
    rd_check(IDX_DRV_CFG, 32'hff, {24'h0, RST_DRV_CFG});
    rd_check(IDX_RATIO_LO, 32'hff, 32'h0);
    rd_check(IDX_CTRL_HI, 32'h0f, 32'h0);
    rd_check(IDX_PHASE, 32'h3f, 32'h0);
    wr(IDX_RATIO_LO, 8'h55, 4'h0, r);
    check_val({30'h0, r}, {30'h0, RESP_OKAY});
    rd_check(IDX_RATIO_LO, 32'hff, 32'h0);
    wr(12'h505, 8'h01, 4'h1, r);
    check_val({30'h0, r}, {30'h0, RESP_SLVERR});
    rd(12'h505, d, r);
    check_val({d[29:0], r}, {30'h0, RESP_SLVERR});
    wr(IDX_PHASE, 8'hff, 4'h1, r);
    rd_check(IDX_PHASE, 32'hff, 32'h3f);
    wr(IDX_PHASE, 8'h00, 4'h1, r);
    foreach (cfg_tab[i]) begin
      wr(IDX_DRV_CFG, cfg_tab[i], 4'h1, r);
      repeat (3) @(posedge mclk);
      check_pins(pin_tab[i], msk_tab[i]);
    end
    wr(IDX_DRV_CFG, 8'h11, 4'h1, r);
    n0 = rise_count;
    repeat (100) @(posedge mclk);
    check_val({16'h0, rise_count}, {16'h0, n0});
    sync_in <= 1'b1;
    repeat (4) @(posedge mclk);
    sync_in <= 1'b0;
    repeat (100) @(posedge mclk);
    check_val({31'h0, rise_count != n0}, 32'h1);
    wr(IDX_RATIO_LO, 8'h03, 4'h1, r);
    wr(IDX_CTRL_HI, 8'h08, 4'h1, r);
    rd_check(IDX_STATUS_CMD, 32'h0a, 32'h08);
    wr(IDX_CTRL_HI, 8'h00, 4'h1, r);
    sync_delay(t0);
    rd_check(IDX_STATUS_CMD, 32'h0a, 32'h02);
    wr(IDX_PHASE, 8'h05, 4'h1, r);
    wr(IDX_CTRL_HI, 8'h08, 4'h1, r);
    wr(IDX_CTRL_HI, 8'h00, 4'h1, r);
    sync_delay(t1);
    check_val(t1 - t0, 32'hf);
    wr(IDX_SYNC_CTRL, 8'h10, 4'h1, r);
    foreach (per_tab[i]) begin
      wr(IDX_RATIO_LO, per_tab[i][31:24], 4'h1, r);
      wr(IDX_CTRL_HI, per_tab[i][23:16], 4'h1, r);
      wait_rises(3);
      check_val({16'h0, last_period}, {16'h0, per_tab[i][15:0]});
    end
    // a masked channel keeps its period through pin and command syncs
    sync_in <= 1'b1;
    wr(IDX_STATUS_CMD, 8'h01, 4'h1, r);
    sync_in <= 1'b0;
    wait_rises(1);
    check_val({16'h0, last_period}, {16'h0, per_tab[4][15:0]});
    rd_check(IDX_STATUS_CMD, 32'h02, 32'h02);
    wr(IDX_CTRL_HI, 8'h08, 4'h1, r);
    repeat (20) @(posedge mclk);
    n0 = rise_count;
    repeat (200) @(posedge mclk);
    check_val({16'h0, rise_count}, {16'h0, n0});
    end_of_test();
  end
endmodule : output_channel_divider_config_tb
